/* File: include/scg_regs.svh */
// register offsets, field positions, reset values and timing counts of the select guard
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH
`define SCG_ADDR_CTRL    4'h0
`define SCG_ADDR_DIV     4'h1
`define SCG_ADDR_TXBUF   4'h2
`define SCG_ADDR_RXBUF   4'h3
`define SCG_ADDR_STAT    4'h4
`define SCG_ADDR_MASK    4'h5
`define SCG_CTRL_SWRST   0
`define SCG_CTRL_MASTER  1
`define SCG_CTRL_FOURPIN 2
`define SCG_CTRL_SELDIR  3
`define SCG_CTRL_RESET   8'h01
`define SCG_DIV_RESET    8'h00
`define SCG_ST_TXF       0
`define SCG_ST_RXF       1
`define SCG_ST_ABORT     2
`define SCG_ST_LOST      3
`define SCG_SYNC_SLACK   9'h004
`define SCG_IDLE_FILL    8'hFF
`define SCG_PAR_HALF     8
`endif

/* File: include/scg_pkg.sv */
// types shared by both ends of the select guard link
package scg_pkg;
    typedef logic [3:0] scg_addr_type;
    typedef logic [7:0] scg_byte_type;
    typedef enum logic [0:0] {SCG_IDLE, SCG_SHIFT} scg_fsm_type;
    typedef struct packed {
        scg_byte_type ctrl;
        scg_byte_type div;
        scg_byte_type txbuf;
        logic         tx_full;
        logic         armed;
        scg_byte_type rxbuf;
        logic [3:0]   stat;
        logic [3:0]   mask;
        scg_byte_type rdata;
        logic         irq;
        logic         lost_cnt;
        scg_fsm_type  fsm;
        scg_byte_type shifter;
        scg_byte_type rxsh;
        logic [2:0]   bitcnt;
        logic [8:0]   divcnt;
        logic [7:0]   pin_o;
        logic [7:0]   s1;
        logic [7:0]   s2;
        logic         sclk_prev;
    } scg_dev_type;
    typedef struct packed {
        scg_fsm_type  fsm;
        scg_byte_type shifter;
        scg_byte_type rxsh;
        scg_byte_type last;
        scg_byte_type rx_data;
        logic         rx_valid;
        logic [2:0]   bitcnt;
        logic [7:0]   divcnt;
        logic [7:0]   pin_o;
        logic [3:0]   s1;
        logic [3:0]   s2;
        logic         sclk_prev;
    } scg_par_type;
endpackage

/* File: include/scg_link_if.sv */
// link between the serial port and its partner, with resolved pin levels
`timescale 1ns/1ps
`default_nettype none
interface scg_link_if;
    // per-pin drive and active-low enable of each party
    logic dev_sclk, dev_sclk_oe_n, dev_mosi, dev_mosi_oe_n;
    logic dev_miso, dev_miso_oe_n, dev_ste, dev_ste_oe_n;
    logic par_sclk, par_sclk_oe_n, par_mosi, par_mosi_oe_n;
    logic par_miso, par_miso_oe_n, par_ste, par_ste_oe_n;
    // resolved levels; undriven clock idles low, others pulled high
    logic sclk, mosi, miso, select_pin;
    assign sclk = !dev_sclk_oe_n ? dev_sclk : (!par_sclk_oe_n ? par_sclk : 1'b0);
    assign mosi = !dev_mosi_oe_n ? dev_mosi : (!par_mosi_oe_n ? par_mosi : 1'b1);
    assign miso = !dev_miso_oe_n ? dev_miso : (!par_miso_oe_n ? par_miso : 1'b1);
    assign select_pin  = !dev_ste_oe_n  ? dev_ste  : (!par_ste_oe_n  ? par_ste  : 1'b1);
    modport dev (
        output dev_sclk, dev_sclk_oe_n, dev_mosi, dev_mosi_oe_n,
        output dev_miso, dev_miso_oe_n, dev_ste, dev_ste_oe_n,
        input  sclk, mosi, miso, select_pin
    );
    modport par (
        output par_sclk, par_sclk_oe_n, par_mosi, par_mosi_oe_n,
        output par_miso, par_miso_oe_n, par_ste, par_ste_oe_n,
        input  sclk, mosi, miso, select_pin
    );
endinterface
`default_nettype wire

/* File: hw/scg_partner.sv */
// far party: spi slave or competing/remote master
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.svh"
module scg_partner #(
    parameter int HALF = `SCG_PAR_HALF
) (
    // clock and reset
    input  wire logic               CLK_I,
    input  wire logic               RST_N_I,
    // link
    scg_link_if.par                 LINK,
    // user side
    input  wire logic               MODE_MASTER_I,
    input  wire logic               LISTEN_I,
    input  wire logic               OWN_BUS_I,
    input  wire logic               START_I,
    input  wire logic               RESEND_I,
    input  wire scg_pkg::scg_byte_type TX_DATA_I,
    output logic [7:0]              RX_DATA_O,
    output logic                    RX_VALID_O,
    output logic                    BUSY_O
);
    import scg_pkg::*;
    if (HALF < 6 || HALF > 255) begin : g_half_check
        $error("HALF out of range");
    end
    scg_par_type r, n;
    logic sclk, mosi, select_pin, miso, rise, fall, sel;
    always_comb begin
        n = r;
        n.s1 = {LINK.sclk, LINK.mosi, LINK.select_pin, LINK.miso};
        n.s2 = r.s1;
        {sclk, mosi, select_pin, miso} = r.s2;
        n.sclk_prev = sclk;
        rise = sclk & !r.sclk_prev;
        fall = !sclk & r.sclk_prev;
        sel = LISTEN_I | !select_pin;
        n.rx_valid = 1'b0;
        if (MODE_MASTER_I) begin
            // pin_o = {sclk, sclk_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, ste, ste_oe_n}
            if (r.fsm == SCG_IDLE) begin
                n.pin_o = 8'h55;
                if (START_I || RESEND_I) begin
                    // R7 resend on request
                    n.shifter = START_I ? TX_DATA_I : r.last;
                    n.last = n.shifter;
                    n.bitcnt = 3'h0;
                    n.divcnt = 8'h00;
                    n.fsm = SCG_SHIFT;
                    n.pin_o = {1'b0, 1'b0, n.shifter[7], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
                end
            end else if (r.divcnt == 8'(HALF - 1)) begin
                n.divcnt = 8'h00;
                if (!r.pin_o[7]) begin
                    n.pin_o[7] = 1'b1;
                    n.rxsh = {r.rxsh[6:0], miso};
                end else begin
                    n.pin_o[7] = 1'b0;
                    n.bitcnt = r.bitcnt + 3'h1;
                    n.shifter = {r.shifter[6:0], 1'b0};
                    n.pin_o[5] = n.shifter[7];
                    if (r.bitcnt == 3'h7) begin
                        n.rx_data = r.rxsh;
                        n.rx_valid = 1'b1;
                        n.fsm = SCG_IDLE;
                        n.pin_o = 8'h55;
                    end
                end
            end else begin
                n.divcnt = r.divcnt + 8'h01;
            end
        end else begin
            n.fsm = SCG_IDLE;
            n.pin_o[7:4] = 4'h5;
            n.pin_o[2] = !sel;
            // claiming the bus tells a guarded master it is inactive
            n.pin_o[1:0] = OWN_BUS_I ? 2'b00 : 2'b11;
            if (!sel) begin
                n.bitcnt = 3'h0;
                n.shifter = TX_DATA_I;
                n.pin_o[3] = TX_DATA_I[7];
            end else if (rise) begin
                n.rxsh = {r.rxsh[6:0], mosi};
                n.bitcnt = r.bitcnt + 3'h1;
                if (r.bitcnt == 3'h7) begin
                    n.rx_data = {r.rxsh[6:0], mosi};
                    n.rx_valid = 1'b1;
                end
            end else if (fall) begin
                n.shifter = (r.bitcnt == 3'h0) ? TX_DATA_I : {r.shifter[6:0], 1'b1};
                n.pin_o[3] = n.shifter[7];
            end
        end
        if (!RST_N_I) begin
            n = '0;
            n.pin_o = 8'h55;
            n.s1 = 4'hF;
            n.s2 = 4'hF;
        end
    end
    always_ff @(posedge CLK_I) begin
        r <= n;
    end
    assign {LINK.par_sclk, LINK.par_sclk_oe_n, LINK.par_mosi, LINK.par_mosi_oe_n} = r.pin_o[7:4];
    assign {LINK.par_miso, LINK.par_miso_oe_n, LINK.par_ste, LINK.par_ste_oe_n} = r.pin_o[3:0];
    assign RX_DATA_O = r.rx_data;
    assign RX_VALID_O = r.rx_valid;
    assign BUSY_O = (r.fsm == SCG_SHIFT);
endmodule // scg_partner
`default_nettype wire

/* File: hw/scg_device.sv */
// serial port with select-pin conflict guard and slave recovery flags
// Operation
// R1 - guarded master reads select as bus-owner input
// R2 - select-direction one drives select as enable
// R3 - select going inactive aborts master transfer
// R4 - after abort software rewrites transmit buffer
// R5 - load transmit buffer only while select active
// R6 - two transmit flags without receive: lost
// R7 - on loss toggle software reset, resend
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.svh"
module scg_device (
    // clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_N_I,
    // register port
    input  wire scg_pkg::scg_addr_type ADDR_I,
    input  wire scg_pkg::scg_byte_type WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic [7:0]                 RDATA_O,
    // interrupt
    output logic                       IRQ_O,
    // link
    scg_link_if.dev                    LINK
);
    import scg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    scg_dev_type r, n;
    logic       master, four, seldir, swrst, guard, master_act, selected;
    logic       sclk, mosi, miso, select_pin, rise, fall, tick;
    logic [3:0] ev;

    always_comb begin
        n = r;
        ev = 4'h0;
        // pin synchronisers: s1 feeds only s2
        n.s1 = {4'h0, LINK.sclk, LINK.mosi, LINK.miso, LINK.select_pin};
        n.s2 = r.s1;
        {sclk, mosi, miso, select_pin} = r.s2[3:0];
        n.sclk_prev = sclk;
        rise = sclk & !r.sclk_prev;
        fall = !sclk & r.sclk_prev;

        swrst = r.ctrl[`SCG_CTRL_SWRST];
        master = r.ctrl[`SCG_CTRL_MASTER];
        four = r.ctrl[`SCG_CTRL_FOURPIN];
        seldir = r.ctrl[`SCG_CTRL_SELDIR];
        // R1 guard input mode
        guard = master & four & !seldir;
        // low select means another master owns the bus
        master_act = !guard | select_pin;
        selected = !four | !select_pin;
        tick = (r.divcnt >= ({1'b0, r.div} + `SCG_SYNC_SLACK));

        ////////////////////////////////////////////////////////////////////////
        // register port, read data valid the cycle after the strobe
        n.rdata = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                `SCG_ADDR_CTRL:  n.rdata = r.ctrl;
                `SCG_ADDR_DIV:   n.rdata = r.div;
                `SCG_ADDR_TXBUF: n.rdata = r.txbuf;
                `SCG_ADDR_RXBUF: n.rdata = r.rxbuf;
                `SCG_ADDR_STAT:  n.rdata = {4'h0, r.stat};
                `SCG_ADDR_MASK:  n.rdata = {4'h0, r.mask};
                default:         n.rdata = 8'h00;
            endcase
        end
        if (WR_I) begin
            case (ADDR_I)
                `SCG_ADDR_CTRL:  n.ctrl = WDATA_I;
                `SCG_ADDR_DIV:   n.div = WDATA_I;
                `SCG_ADDR_TXBUF: begin
                    // R4 rewrite refills buffer
                    n.txbuf = WDATA_I;
                    n.tx_full = !swrst;
                    n.stat[`SCG_ST_TXF] = 1'b0;
                end
                `SCG_ADDR_STAT:  n.stat = r.stat & ~WDATA_I[3:0];
                `SCG_ADDR_MASK:  n.mask = WDATA_I[3:0];
                default:         n.stat = n.stat;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        if (swrst) begin
            // R7 software reset reinitialises
            n.fsm = SCG_IDLE;
            n.tx_full = 1'b0;
            n.armed = 1'b0;
            n.bitcnt = 3'h0;
            n.divcnt = 9'h000;
            n.lost_cnt = 1'b0;
            n.stat = 4'h0;
            n.pin_o = 8'h55;
            ev[`SCG_ST_TXF] = 1'b1;
        end else if (master) begin
            // pin_o = {sclk, sclk_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, ste, ste_oe_n}
            n.pin_o[6] = !master_act;
            n.pin_o[4] = !master_act;
            n.pin_o[3:2] = 2'b11;
            // R2 select as enable output
            n.pin_o[0] = !(four & seldir);
            n.pin_o[1] = !(r.fsm == SCG_SHIFT);
            case (r.fsm)
                SCG_IDLE: begin
                    n.pin_o[7] = 1'b0;
                    n.pin_o[1] = 1'b1;
                    // R5 data waits for master-active select
                    if (r.tx_full && master_act) begin
                        n.shifter = r.txbuf;
                        n.tx_full = 1'b0;
                        ev[`SCG_ST_TXF] = 1'b1;
                        n.bitcnt = 3'h0;
                        n.divcnt = 9'h000;
                        n.pin_o[5] = r.txbuf[7];
                        n.pin_o[1] = 1'b0;
                        n.fsm = SCG_SHIFT;
                    end
                end
                SCG_SHIFT: begin
                    if (!master_act) begin
                        // R3 abort, byte is lost
                        n.fsm = SCG_IDLE;
                        n.pin_o[7] = 1'b0;
                        n.pin_o[1] = 1'b1;
                        ev[`SCG_ST_ABORT] = 1'b1;
                    end else if (tick) begin
                        n.divcnt = 9'h000;
                        if (!r.pin_o[7]) begin
                            n.pin_o[7] = 1'b1;
                            n.rxsh = {r.rxsh[6:0], miso};
                        end else begin
                            n.pin_o[7] = 1'b0;
                            n.bitcnt = r.bitcnt + 3'h1;
                            n.shifter = {r.shifter[6:0], 1'b0};
                            n.pin_o[5] = n.shifter[7];
                            if (r.bitcnt == 3'h7) begin
                                n.rxbuf = r.rxsh;
                                ev[`SCG_ST_RXF] = 1'b1;
                                n.pin_o[1] = 1'b1;
                                n.fsm = SCG_IDLE;
                            end
                        end
                    end else begin
                        n.divcnt = r.divcnt + 9'h001;
                    end
                end
                default: n.fsm = SCG_IDLE;
            endcase
        end else begin
            // slave: pins sampled after the synchroniser
            n.fsm = SCG_IDLE;
            n.pin_o[7:4] = 4'h5;
            n.pin_o[1:0] = 2'b11;
            n.pin_o[2] = !selected;
            // load at frame start, so in four-pin mode a byte written after mode entry is the one sent; three-pin loads on mode entry
            if (!selected) begin
                n.bitcnt = 3'h0;
                n.armed = 1'b0;
            end
            if (selected && r.bitcnt == 3'h0 && !r.armed && !sclk) begin
                n.armed = 1'b1;
                if (r.tx_full) begin
                    n.shifter = r.txbuf;
                    n.tx_full = 1'b0;
                    ev[`SCG_ST_TXF] = 1'b1;
                end else begin
                    n.shifter = `SCG_IDLE_FILL;
                end
                n.pin_o[3] = n.shifter[7];
            end else if (selected && rise) begin
                n.rxsh = {r.rxsh[6:0], mosi};
                n.bitcnt = r.bitcnt + 3'h1;
                if (r.bitcnt == 3'h7) begin
                    n.rxbuf = {r.rxsh[6:0], mosi};
                    ev[`SCG_ST_RXF] = 1'b1;
                end
            end else if (selected && fall) begin
                n.shifter = {r.shifter[6:0], 1'b1};
                n.pin_o[3] = n.shifter[7];
                if (r.bitcnt == 3'h0) begin
                    n.armed = 1'b0;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // R6 second transmit flag without receive
        if (ev[`SCG_ST_RXF]) begin
            n.lost_cnt = 1'b0;
        end else if (ev[`SCG_ST_TXF] && !swrst) begin
            n.lost_cnt = 1'b1;
            ev[`SCG_ST_LOST] = r.lost_cnt;
        end
        // set beats a same-cycle clear
        n.stat = n.stat | ev;
        n.irq = |(n.stat & r.mask);

        if (!RST_N_I) begin
            n = '0;
            n.ctrl = `SCG_CTRL_RESET;
            n.div = `SCG_DIV_RESET;
            n.pin_o = 8'h55;
            n.s1 = 8'h0F;
            n.s2 = 8'h0F;
        end
    end

    always_ff @(posedge CLK_I) begin
        r <= n;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign {LINK.dev_sclk, LINK.dev_sclk_oe_n, LINK.dev_mosi, LINK.dev_mosi_oe_n} = r.pin_o[7:4];
    assign {LINK.dev_miso, LINK.dev_miso_oe_n, LINK.dev_ste, LINK.dev_ste_oe_n} = r.pin_o[3:0];
    assign RDATA_O = r.rdata;
    assign IRQ_O = r.irq;
endmodule // scg_device
`default_nettype wire

/* File: testbench/scg_link_checker.sv */
// link-level assertions for the select guard serial port
`timescale 1ns/1ps
`default_nettype none
module scg_link_checker (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // link signals
    input wire logic dev_sclk_oe_n,
    input wire logic dev_mosi_oe_n,
    input wire logic dev_ste_oe_n,
    input wire logic dev_ste,
    input wire logic par_sclk_oe_n,
    input wire logic par_mosi_oe_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic select_pin
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    sclk_conflict_a: assert property (dev_sclk_oe_n || par_sclk_oe_n)
        else $error("both ends drive the serial clock");
    mosi_conflict_a: assert property (dev_mosi_oe_n || par_mosi_oe_n)
        else $error("both ends drive the data out line");
    // two sync flops plus a register: six cycles is generous
    guard_release_a: assert property (
        (dev_ste_oe_n && !select_pin) [*6] |-> dev_sclk_oe_n && dev_mosi_oe_n)
        else $error("master kept driving while select was low");
    guard_abort_a: assert property (
        $fell(select_pin) && dev_ste_oe_n && !dev_sclk_oe_n |-> ##[1:6] dev_mosi_oe_n)
        else $error("transfer not abandoned after select went low");
    frame_clock_a: assert property (!dev_ste_oe_n && $rose(sclk) |-> !select_pin)
        else $error("clock edge outside the select frame");
    idle_clock_a: assert property (!dev_ste_oe_n && dev_ste |-> !sclk)
        else $error("clock not idle low while select high");
    mosi_drive_a: assert property (!dev_sclk_oe_n && $rose(sclk) |-> !dev_mosi_oe_n)
        else $error("data line released during clocking");
    mosi_hold_a: assert property (!dev_sclk_oe_n && $rose(sclk) |-> $stable(mosi))
        else $error("data line changed at the sampling edge");
endmodule // scg_link_checker
`default_nettype wire

/* File: testbench/spi_select_conflict_guard_tb.sv */
// self-checking bench: device against partner over the link
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.svh"
module spi_select_conflict_guard_tb;
    import scg_pkg::*;
    logic         clk, rst_n, wr, rd, irq, mm, listen, own, start, resend, pvalid, pbusy;
    scg_addr_type addr;
    scg_byte_type wdata, rdata, ptx, prx, b, d, p;
    int           failures, n_tests;
    scg_link_if link ();
    scg_device scg_device_inst (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .LINK(link));
    scg_partner scg_partner_inst (.CLK_I(clk), .RST_N_I(rst_n), .LINK(link),
        .MODE_MASTER_I(mm), .LISTEN_I(listen), .OWN_BUS_I(own), .START_I(start),
        .RESEND_I(resend), .TX_DATA_I(ptx), .RX_DATA_O(prx), .RX_VALID_O(pvalid), .BUSY_O(pbusy));
    scg_link_checker scg_link_checker_inst (.CLK_I(clk), .RST_N_I(rst_n),
        .dev_sclk_oe_n(link.dev_sclk_oe_n), .dev_mosi_oe_n(link.dev_mosi_oe_n),
        .dev_ste_oe_n(link.dev_ste_oe_n), .dev_ste(link.dev_ste),
        .par_sclk_oe_n(link.par_sclk_oe_n), .par_mosi_oe_n(link.par_mosi_oe_n),
        .sclk(link.sclk), .mosi(link.mosi), .select_pin(link.select_pin));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input scg_addr_type a, input scg_byte_type v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input scg_addr_type a, output scg_byte_type v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for the partner's one-cycle receive pulse
    task automatic wait_rx();
        for (int i = 0; i < 1000 && pvalid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("partner receive pulse", 8'h01, {7'h00, pvalid});
    endtask
    task automatic pulse(input logic again);
        @(posedge clk);
        if (again) resend <= 1'b1;
        else start <= 1'b1;
        @(posedge clk);
        start  <= 1'b0;
        resend <= 1'b0;
    endtask
    function automatic scg_byte_type stat_exp(input logic txf, rxf, abrt, lost);
        return {4'h0, lost, abrt, rxf, txf};
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[FAIL] watchdog expected finish seen hang");
        conclude();
    end
    initial begin
        clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        mm = 1'b0; listen = 1'b0; own = 1'b0; start = 1'b0; resend = 1'b0; ptx = 8'h00;
        b = scg_byte_type'($urandom(32'h1f6b));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`SCG_ADDR_CTRL, d);
        chk("ctrl reset", `SCG_CTRL_RESET, d);
        rd_reg(`SCG_ADDR_DIV, d);
        chk("div reset", `SCG_DIV_RESET, d);
        rd_reg(4'hF, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset values done");
        wr_reg(`SCG_ADDR_MASK, 8'h0F);
        wr_reg(`SCG_ADDR_CTRL, 8'h0E);
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : scg_byte_type'($urandom);
            wr_reg(`SCG_ADDR_TXBUF, b);
            wait_rx();
            chk("select output byte", b, prx);
            repeat (20) @(posedge clk);
        end
        #1 chk("irq with flags", 8'h01, {7'h00, irq});
        wr_reg(`SCG_ADDR_MASK, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk("irq masked", 8'h00, {7'h00, irq});
        wr_reg(`SCG_ADDR_MASK, 8'h0F);
        wr_reg(`SCG_ADDR_STAT, 8'h0F);
        repeat (3) @(posedge clk);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test select output done");
        // long half period so the abort lands before the first clock edge
        @(posedge clk) listen <= 1'b1;
        wr_reg(`SCG_ADDR_DIV, 8'h20);
        wr_reg(`SCG_ADDR_CTRL, 8'h06);
        wr_reg(`SCG_ADDR_TXBUF, scg_byte_type'($urandom));
        repeat (5) @(posedge clk);
        own <= 1'b1;
        repeat (10) @(posedge clk);
        rd_reg(`SCG_ADDR_STAT, d);
        chk("abort flag", 8'h04, d & 8'h04);
        @(posedge clk) own <= 1'b0;
        repeat (6) @(posedge clk);
        wr_reg(`SCG_ADDR_STAT, 8'h0F);
        b = scg_byte_type'($urandom);
        wr_reg(`SCG_ADDR_TXBUF, b);
        wait_rx();
        chk("rewritten byte", b, prx);
        repeat (80) @(posedge clk);
        rd_reg(`SCG_ADDR_STAT, d);
        chk("lost flag", 8'h08, d & 8'h08);
        $display("test guard abort done");
        wr_reg(`SCG_ADDR_CTRL, 8'h07);
        wr_reg(`SCG_ADDR_CTRL, 8'h06);
        rd_reg(`SCG_ADDR_STAT, d);
        chk("stat after soft reset", stat_exp(1'b1, 1'b0, 1'b0, 1'b0), d);
        $display("test soft reset done");
        @(posedge clk) begin
            listen <= 1'b0;
            mm     <= 1'b1;
            p       = scg_byte_type'($urandom);
            ptx    <= p;
        end
        wr_reg(`SCG_ADDR_CTRL, 8'h04);
        b = scg_byte_type'($urandom);
        wr_reg(`SCG_ADDR_TXBUF, b);
        pulse(1'b0);
        #1 chk("partner busy", 8'h01, {7'h00, pbusy});
        wait_rx();
        chk("slave answer", b, prx);
        chk("partner idle", 8'h00, {7'h00, pbusy});
        repeat (10) @(posedge clk);
        rd_reg(`SCG_ADDR_RXBUF, d);
        chk("slave received", p, d);
        wr_reg(`SCG_ADDR_CTRL, 8'h05);
        wr_reg(`SCG_ADDR_CTRL, 8'h04);
        pulse(1'b1);
        wait_rx();
        chk("idle fill after reinit", `SCG_IDLE_FILL, prx);
        repeat (10) @(posedge clk);
        rd_reg(`SCG_ADDR_RXBUF, d);
        chk("resent byte received", p, d);
        $display("test slave recovery done");
        conclude();
    end
endmodule // spi_select_conflict_guard_tb
`default_nettype wire
